/* hdl/csbc_pkg.sv */
// csbc_pkg: constants, encodings and state codes for the special bus cycle logic.
// assumes one 200 MHz processor clock and a synchronous active-high reset.
// Behaviour
// - int acknowledge is exactly two bus operations
// - latch low-byte vector during second acknowledge
// - atomic access low in first status phase
// - atomic access held through second acknowledge
// - no foreign grant until acknowledge ends
// - three idle clocks between acknowledge operations
// - fixed local bus grant priority order
// - prefetch suppressed two clocks before data
// - halt instruction or multiple faults enter halt
// - halt/shutdown status code, addr bit 1 selects
// - halted device still serves operand, foreign requests
// - overrun during shutdown blocks operand service
// - exit conditions for halt and shutdown
// - stopped clock holds outputs, resumes in place
// - foreign grant given, withdrawn before own cycles
package csbc_pkg;
  localparam int REQ_W = 7;
  localparam int VEC_W = 8;
  // request bit positions, higher index wins
  localparam int REQ_LOCKED = 6;
  localparam int REQ_ODD_SECOND = 5;
  localparam int REQ_COPROC_NEXT = 4;
  localparam int REQ_FOREIGN = 3;
  localparam int REQ_COPROC_OPND = 2;
  localparam int REQ_EXEC_DATA = 1;
  localparam int REQ_PREFETCH = 0;
  // status word {status_line_1, status_line_0, code_or_ack_n, mem_or_io}
  localparam int STAT_LINE1_BIT = 3;
  localparam int STAT_LINE0_BIT = 2;
  localparam int STAT_CODE_BIT = 1;
  localparam int STAT_MIO_BIT = 0;
  localparam logic [3:0] STAT_IDLE = 4'hF;
  localparam logic [3:0] STAT_INT_ACK = 4'h0;
  localparam logic [3:0] STAT_HALT = 4'h1;
  // timing counts in processor clocks
  localparam logic [1:0] ACK_GAP_CLOCKS = 2'h3;
  localparam logic [2:0] PREFETCH_LEAD_CLOCKS = 3'h2;
  // reset values
  localparam logic RST_ATOMIC_N = 1'h1;
  localparam logic RST_READY_N = 1'h1;
  localparam logic RST_ADDR_BIT_1 = 1'h0;

  // _SP is a status phase state, _CP a command phase state
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ACK1_SP = 4'h1,
    ST_ACK1_CP = 4'h2,
    ST_ACK_GAP = 4'h3,
    ST_ACK2_SP = 4'h4,
    ST_ACK2_CP = 4'h5,
    ST_HALT_SP = 4'h6,
    ST_HOLD = 4'h7,
    ST_HOLD_EXIT = 4'h8
  } csbc_state_t;
endpackage

/* hdl/csbc_arb_if.sv */
// csbc_arb_if: request vector and one-hot grant between core and arbiter.
// assumes both ends run on the processor clock.
`timescale 1ns/1ps
interface csbc_arb_if;
  logic [csbc_pkg::REQ_W-1:0] req;
  logic [csbc_pkg::REQ_W-1:0] gnt;
  modport arb (input req, output gnt);
  modport core (output req, input gnt);
endinterface

/* hdl/csbc_arb.sv */
// csbc_arb: fixed-priority local bus arbiter, purely combinational.
// assumes requests are already masked for halt and prefetch lead.
`timescale 1ns/1ps
module csbc_arb (
  input wire logic i_clock,
  input wire logic i_rst,
  csbc_arb_if.arb bus
);
  function automatic logic [csbc_pkg::REQ_W-1:0] pick_top(
    input logic [csbc_pkg::REQ_W-1:0] req);
    logic [csbc_pkg::REQ_W-1:0] g;
    g = '0;
    for (int i = 0; i < csbc_pkg::REQ_W; i++) begin
      if (req[i]) begin
        g = '0;
        g[i] = 1'b1;
      end
    end
    return g;
  endfunction

  always_comb begin
    bus.gnt = pick_top(bus.req);
  end

  a_grant_top_wins: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (|bus.req) |-> ($onehot(bus.gnt) && ((bus.gnt & bus.req) != '0)
      && ((bus.req & ~(bus.gnt | (bus.gnt - 7'h01))) == '0)))
    else $error("arbiter granted a lower priority request");

  a_grant_none_idle: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (bus.req == '0) |-> (bus.gnt == '0))
    else $error("arbiter granted with no request");
endmodule

/* hdl/csbc_top.sv */
// csbc_top: interrupt acknowledge, halt/shutdown, hold and bus priority.
// assumes pins arrive asynchronously; core-side inputs share i_clock.
`timescale 1ns/1ps
module csbc_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_int_request,
  input wire logic i_nonmaskable_int,
  input wire logic i_foreign_master_request,
  input wire logic i_coproc_operand_req,
  input wire logic i_ready_n,
  input wire logic [7:0] i_data_low,
  input wire logic i_int_enable,
  input wire logic i_halt_instruction,
  input wire logic i_multi_prot_fault,
  input wire logic i_coproc_seg_overrun,
  input wire logic i_locked_req,
  input wire logic i_odd_second_req,
  input wire logic i_coproc_next_req,
  input wire logic i_exec_data_req,
  input wire logic i_exec_data_pending,
  input wire logic [2:0] i_exec_data_lead,
  input wire logic i_prefetch_req,
  output logic o_status_line_1,
  output logic o_status_line_0,
  output logic o_code_or_ack_n,
  output logic o_mem_or_io,
  output logic o_addr_bit_1,
  output logic o_atomic_access_n,
  output logic o_int_ack_cycle,
  output logic o_foreign_master_grant,
  output logic [6:0] o_grant,
  output logic [7:0] o_vector,
  output logic o_vector_valid,
  output logic o_halted,
  output logic o_shutdown
);
  typedef struct packed {
    csbc_pkg::csbc_state_t state;
    logic [1:0] gap_cnt;
    logic halted;
    logic shut;
    logic opnd_block;
    logic int_meta;
    logic int_s2;
    logic nmi_meta;
    logic nmi_s2;
    logic fmr_meta;
    logic fmr_s2;
    logic cpr_meta;
    logic cpr_s2;
    logic rdy_meta;
    logic rdy_s2;
    logic [7:0] data_meta;
    logic [7:0] data_s2;
    logic [3:0] status;
    logic int_ack;
    logic atomic_n;
    logic addr_bit_1;
    logic fm_grant;
    logic [6:0] grant;
    logic [7:0] vector;
    logic vec_valid;
  } csbc_regs_t;

  csbc_regs_t regs_ff;
  csbc_regs_t nxt_regs;

  csbc_arb_if u_arb_bus();

  csbc_arb u_arb (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .bus(u_arb_bus)
  );

  // acknowledge bus operations proper, gap excluded
  function automatic logic is_ack_op(input csbc_pkg::csbc_state_t st);
    return (st == csbc_pkg::ST_ACK1_SP) || (st == csbc_pkg::ST_ACK1_CP)
      || (st == csbc_pkg::ST_ACK2_SP) || (st == csbc_pkg::ST_ACK2_CP);
  endfunction

  logic int_ok;
  logic ready;
  logic start_ack;
  logic start_halt;
  logic arb_go;
  logic pf_block;
  logic [6:0] req;

  always_comb begin
    int_ok = regs_ff.int_s2 && i_int_enable;
    ready = !regs_ff.rdy_s2;
    start_ack = !regs_ff.halted && int_ok;
    start_halt = !regs_ff.halted && !int_ok && (i_halt_instruction || i_multi_prot_fault);
    arb_go = (regs_ff.state == csbc_pkg::ST_IDLE) && !start_ack && !start_halt;
    // prefetch would make the coming data transfer wait
    pf_block = i_exec_data_pending
      && (i_exec_data_lead <= csbc_pkg::PREFETCH_LEAD_CLOCKS);
    req = '0;
    if (arb_go) begin
      req[csbc_pkg::REQ_FOREIGN] = regs_ff.fmr_s2;
      req[csbc_pkg::REQ_COPROC_OPND] = regs_ff.cpr_s2 && !regs_ff.opnd_block;
      if (!regs_ff.halted) begin
        req[csbc_pkg::REQ_LOCKED] = i_locked_req;
        req[csbc_pkg::REQ_ODD_SECOND] = i_odd_second_req;
        req[csbc_pkg::REQ_COPROC_NEXT] = i_coproc_next_req;
        req[csbc_pkg::REQ_EXEC_DATA] = i_exec_data_req;
        req[csbc_pkg::REQ_PREFETCH] = i_prefetch_req && !pf_block;
      end
    end
    u_arb_bus.req = req;
  end

  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.int_meta = i_int_request;
    nxt_regs.int_s2 = regs_ff.int_meta;
    nxt_regs.nmi_meta = i_nonmaskable_int;
    nxt_regs.nmi_s2 = regs_ff.nmi_meta;
    nxt_regs.fmr_meta = i_foreign_master_request;
    nxt_regs.fmr_s2 = regs_ff.fmr_meta;
    nxt_regs.cpr_meta = i_coproc_operand_req;
    nxt_regs.cpr_s2 = regs_ff.cpr_meta;
    nxt_regs.rdy_meta = i_ready_n;
    nxt_regs.rdy_s2 = regs_ff.rdy_meta;
    nxt_regs.data_meta = i_data_low;
    nxt_regs.data_s2 = regs_ff.data_meta;
    nxt_regs.grant = '0;
    nxt_regs.vec_valid = 1'b0;

    if (regs_ff.halted) begin
      // shutdown is not left on maskable interrupts or overruns
      if (regs_ff.nmi_s2 || (!regs_ff.shut && (int_ok || i_coproc_seg_overrun))) begin
        nxt_regs.halted = 1'b0;
        nxt_regs.shut = 1'b0;
        nxt_regs.opnd_block = 1'b0;
      end else if (regs_ff.shut && i_coproc_seg_overrun) begin
        nxt_regs.opnd_block = 1'b1;
      end
    end

    case (regs_ff.state)
      csbc_pkg::ST_IDLE: begin
        if (start_ack) begin
          nxt_regs.state = csbc_pkg::ST_ACK1_SP;
        end else if (start_halt) begin
          nxt_regs.state = csbc_pkg::ST_HALT_SP;
          nxt_regs.halted = 1'b1;
          nxt_regs.shut = !i_halt_instruction;
          nxt_regs.addr_bit_1 = i_halt_instruction;
        end else if (u_arb_bus.gnt[csbc_pkg::REQ_FOREIGN]) begin
          nxt_regs.state = csbc_pkg::ST_HOLD;
        end else begin
          nxt_regs.grant = u_arb_bus.gnt;
        end
      end
      csbc_pkg::ST_ACK1_SP: begin
        nxt_regs.state = csbc_pkg::ST_ACK1_CP;
      end
      csbc_pkg::ST_ACK1_CP: begin
        if (ready) begin
          nxt_regs.state = csbc_pkg::ST_ACK_GAP;
          nxt_regs.gap_cnt = csbc_pkg::ACK_GAP_CLOCKS - 2'h1;
        end
      end
      csbc_pkg::ST_ACK_GAP: begin
        if (regs_ff.gap_cnt == 2'h0) begin
          nxt_regs.state = csbc_pkg::ST_ACK2_SP;
        end else begin
          nxt_regs.gap_cnt = regs_ff.gap_cnt - 2'h1;
        end
      end
      csbc_pkg::ST_ACK2_SP: begin
        nxt_regs.state = csbc_pkg::ST_ACK2_CP;
      end
      csbc_pkg::ST_ACK2_CP: begin
        // outside ready logic stretches this operation
        if (ready) begin
          nxt_regs.state = csbc_pkg::ST_IDLE;
          nxt_regs.vector = regs_ff.data_s2;
          nxt_regs.vec_valid = 1'b1;
        end
      end
      csbc_pkg::ST_HALT_SP: begin
        // no ready wait: the operation ends by itself
        nxt_regs.state = csbc_pkg::ST_IDLE;
      end
      csbc_pkg::ST_HOLD: begin
        if (!regs_ff.fmr_s2) begin
          nxt_regs.state = csbc_pkg::ST_HOLD_EXIT;
        end
      end
      csbc_pkg::ST_HOLD_EXIT: begin
        nxt_regs.state = csbc_pkg::ST_IDLE;
      end
      default: begin
        nxt_regs.state = csbc_pkg::ST_IDLE;
      end
    endcase

    // outputs follow the state being entered, so they leave flip-flops
    if ((nxt_regs.state == csbc_pkg::ST_ACK1_SP) || (nxt_regs.state == csbc_pkg::ST_ACK2_SP)) begin
      nxt_regs.status = csbc_pkg::STAT_INT_ACK;
    end else if (nxt_regs.state == csbc_pkg::ST_HALT_SP) begin
      nxt_regs.status = csbc_pkg::STAT_HALT;
    end else begin
      nxt_regs.status = csbc_pkg::STAT_IDLE;
    end
    nxt_regs.int_ack = is_ack_op(nxt_regs.state);
    // lock spans the gap too, so no arbiter splits the pair
    nxt_regs.atomic_n = !(is_ack_op(nxt_regs.state)
      || (nxt_regs.state == csbc_pkg::ST_ACK_GAP));
    nxt_regs.fm_grant = (nxt_regs.state == csbc_pkg::ST_HOLD);
  end

  // a stopped clock simply freezes this register, outputs included
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      regs_ff <= '0;
      regs_ff.status <= csbc_pkg::STAT_IDLE;
      regs_ff.atomic_n <= csbc_pkg::RST_ATOMIC_N;
      regs_ff.addr_bit_1 <= csbc_pkg::RST_ADDR_BIT_1;
      regs_ff.rdy_meta <= csbc_pkg::RST_READY_N;
      regs_ff.rdy_s2 <= csbc_pkg::RST_READY_N;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  assign o_status_line_1 = regs_ff.status[csbc_pkg::STAT_LINE1_BIT];
  assign o_status_line_0 = regs_ff.status[csbc_pkg::STAT_LINE0_BIT];
  assign o_code_or_ack_n = regs_ff.status[csbc_pkg::STAT_CODE_BIT];
  assign o_mem_or_io = regs_ff.status[csbc_pkg::STAT_MIO_BIT];
  assign o_addr_bit_1 = regs_ff.addr_bit_1;
  assign o_atomic_access_n = regs_ff.atomic_n;
  assign o_int_ack_cycle = regs_ff.int_ack;
  assign o_foreign_master_grant = regs_ff.fm_grant;
  assign o_grant = regs_ff.grant;
  assign o_vector = regs_ff.vector;
  assign o_vector_valid = regs_ff.vec_valid;
  assign o_halted = regs_ff.halted;
  assign o_shutdown = regs_ff.shut;

  a_ack_gap_three: assert property (
    @(posedge i_clock) disable iff (i_rst)
    ($fell(o_int_ack_cycle) && !o_atomic_access_n)
      |-> (!o_int_ack_cycle && !o_atomic_access_n)[*3] ##1 o_int_ack_cycle)
    else $error("acknowledge gap is not three idle clocks");

  a_ack_pair_end: assert property (
    @(posedge i_clock) disable iff (i_rst)
    ($fell(o_int_ack_cycle) && o_atomic_access_n)
      |-> ($past(regs_ff.state) == csbc_pkg::ST_ACK2_CP))
    else $error("acknowledge sequence ended after other than second operation");

  a_lock_first_ts: assert property (
    @(posedge i_clock) disable iff (i_rst)
    ($rose(o_int_ack_cycle) && $past(o_atomic_access_n))
      |-> (!o_atomic_access_n && !o_status_line_1 && !o_status_line_0
        && !o_code_or_ack_n && !o_mem_or_io))
    else $error("atomic access not low in first acknowledge status phase");

  a_lock_through_ack: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (regs_ff.state == csbc_pkg::ST_ACK2_CP) |-> !o_atomic_access_n)
    else $error("atomic access released before second acknowledge ended");

  a_no_hold_in_ack: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (!o_atomic_access_n || !$past(o_atomic_access_n)) |-> !o_foreign_master_grant)
    else $error("foreign master granted inside acknowledge sequence");

  a_vector_latch: assert property (
    @(posedge i_clock) disable iff (i_rst)
    ((regs_ff.state == csbc_pkg::ST_ACK2_CP) && !regs_ff.rdy_s2)
      |=> (o_vector_valid && (o_vector == $past(regs_ff.data_s2))))
    else $error("vector not latched at end of second acknowledge");

  a_halt_encode: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (regs_ff.state == csbc_pkg::ST_HALT_SP)
      |-> (!o_status_line_1 && !o_status_line_0 && !o_code_or_ack_n && o_mem_or_io
        && (o_addr_bit_1 == !o_shutdown)))
    else $error("halt or shutdown status encoding wrong");

  a_halt_entry: assert property (
    @(posedge i_clock) disable iff (i_rst)
    ((regs_ff.state == csbc_pkg::ST_IDLE) && !regs_ff.halted && !int_ok
      && i_halt_instruction)
      |=> ((regs_ff.state == csbc_pkg::ST_HALT_SP) && o_addr_bit_1 && o_halted)
      ##1 (regs_ff.state == csbc_pkg::ST_IDLE))
    else $error("halt instruction did not produce a halt operation");

  a_shut_holds: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (o_shutdown && !regs_ff.nmi_s2) |=> o_shutdown)
    else $error("shutdown left without nonmaskable interrupt or reset");

  a_opnd_blocked: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (regs_ff.opnd_block && $past(regs_ff.opnd_block))
      |-> !o_grant[csbc_pkg::REQ_COPROC_OPND])
    else $error("operand request served after overrun in shutdown");

  a_prefetch_lead: assert property (
    @(posedge i_clock) disable iff (i_rst)
    (i_exec_data_pending && (i_exec_data_lead <= csbc_pkg::PREFETCH_LEAD_CLOCKS))
      |=> !o_grant[csbc_pkg::REQ_PREFETCH])
    else $error("prefetch granted inside data transfer lead time");

  a_grant_withdrawn: assert property (
    @(posedge i_clock) disable iff (i_rst)
    $fell(o_foreign_master_grant) |-> ((o_grant == '0) && !o_int_ack_cycle))
    else $error("own cycle started while grant was being withdrawn");
endmodule

/* sim/csbc_ack_partner.sv */
// csbc_ack_partner: interrupt controller plus ready logic facing the acknowledge cycles.
// assumes the design sees ready and data through two sync stages of equal latency.
`timescale 1ns/1ps
module csbc_ack_partner (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_int_ack_cycle,
  input wire logic [3:0] i_wait_clocks,
  input wire logic [7:0] i_vector,
  output logic o_ready_n,
  output logic [7:0] o_data_low
);
  logic ack_d_ff;
  logic second_ff;
  logic [3:0] cnt_ff;
  logic drive;
  logic cascade_en;
  // command controller side: cascade address only goes out during acknowledge
  assign cascade_en = i_int_ack_cycle;
  // ready held back for the wait states, so both operations get stretched
  assign drive = cascade_en && ack_d_ff && (cnt_ff >= i_wait_clocks);
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_d_ff <= 1'b0;
      second_ff <= 1'b1;
      cnt_ff <= 4'h0;
      o_ready_n <= 1'b1;
      o_data_low <= 8'h5A;
    end else begin
      ack_d_ff <= i_int_ack_cycle;
      if (i_int_ack_cycle && !ack_d_ff) begin
        second_ff <= !second_ff; // source of the vector settled in the first operation
        cnt_ff <= 4'h0;
      end else if (i_int_ack_cycle) begin
        cnt_ff <= cnt_ff + 4'h1;
      end
      // released ready is pulled inactive
      o_ready_n <= !drive;
      // vector only with ready in the second operation, else a moving pattern
      o_data_low <= (drive && second_ff) ? i_vector : ~o_data_low;
    end
  end
endmodule

/* sim/cpu_special_bus_cycles_test.sv */
// cpu_special_bus_cycles_test: self-checking bench for the special bus cycle block.
// assumes csbc_top with the acknowledge partner on its ready and data pins.
`timescale 1ns/1ps
module cpu_special_bus_cycles_test;
  logic i_clock = 1'b0;
  logic clk_run = 1'b1;
  logic i_rst;
  logic i_int_request, i_nonmaskable_int, i_foreign_master_request, i_coproc_operand_req;
  logic i_int_enable, i_halt_instruction, i_multi_prot_fault, i_coproc_seg_overrun;
  logic i_locked_req, i_odd_second_req, i_coproc_next_req, i_exec_data_req, i_prefetch_req;
  logic i_exec_data_pending;
  logic [2:0] i_exec_data_lead;
  logic [3:0] wait_clocks;
  logic [7:0] vec;
  logic ready_n;
  logic [7:0] data_low;
  logic o_status_line_1, o_status_line_0, o_code_or_ack_n, o_mem_or_io;
  logic o_addr_bit_1, o_atomic_access_n, o_int_ack_cycle, o_foreign_master_grant;
  logic o_vector_valid, o_halted, o_shutdown;
  logic [6:0] o_grant;
  logic [7:0] o_vector;
  int num_errors = 0;
  int samples_checked = 0;
  int k, n, m, rises, gap;
  logic [31:0] r;
  logic prev, seen, bad;
  logic [7:0] snap;
  wire logic [3:0] stat;
  assign stat = {o_status_line_1, o_status_line_0, o_code_or_ack_n, o_mem_or_io};

  // stopping just holds the level, so restart is at the same level
  always #2.5 if (clk_run) i_clock = ~i_clock;

  csbc_top csbc_top_inst (.i_clock, .i_rst, .i_int_request, .i_nonmaskable_int,
    .i_foreign_master_request, .i_coproc_operand_req, .i_ready_n(ready_n),
    .i_data_low(data_low), .i_int_enable, .i_halt_instruction, .i_multi_prot_fault,
    .i_coproc_seg_overrun, .i_locked_req, .i_odd_second_req, .i_coproc_next_req,
    .i_exec_data_req, .i_exec_data_pending, .i_exec_data_lead, .i_prefetch_req,
    .o_status_line_1, .o_status_line_0, .o_code_or_ack_n, .o_mem_or_io, .o_addr_bit_1,
    .o_atomic_access_n, .o_int_ack_cycle, .o_foreign_master_grant, .o_grant, .o_vector,
    .o_vector_valid, .o_halted, .o_shutdown);

  csbc_ack_partner csbc_ack_partner_inst (.i_clock, .i_rst, .i_int_ack_cycle(o_int_ack_cycle),
    .i_wait_clocks(wait_clocks), .i_vector(vec), .o_ready_n(ready_n), .o_data_low(data_low));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge i_clock);
  endtask

  task automatic give_verdict();
    $display("counts: %0d compared, %0d mismatched", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reference arbiter: highest set request wins, foreign never on the internal grant
  function automatic logic [6:0] exp_grant(logic [6:0] req, logic pend, logic [2:0] lead);
    int i;
    if (pend && lead <= csbc_pkg::PREFETCH_LEAD_CLOCKS) req[0] = 1'b0;
    for (i = 6; i >= 0; i--) if (req[i] && i != 3) return 7'h01 << i;
    return 7'h00;
  endfunction

  initial begin
    #20000;
    num_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    give_verdict();
  end

  initial begin
    i_rst = 1'b1;
    {i_int_request, i_nonmaskable_int, i_foreign_master_request, i_coproc_operand_req} = '0;
    {i_int_enable, i_halt_instruction, i_multi_prot_fault, i_coproc_seg_overrun} = '0;
    {i_locked_req, i_odd_second_req, i_coproc_next_req, i_exec_data_req, i_prefetch_req} = '0;
    i_exec_data_pending = 1'b0;
    i_exec_data_lead = 3'h0;
    wait_clocks = 4'h1;
    vec = 8'h00;
    void'($urandom(18));
    cyc(5);
    i_rst = 1'b0;
    cyc(1);
    check("idle status", 8'h0F, stat);
    check("idle lock", 8'h01, o_atomic_access_n);
    check("idle grant", 8'h00, o_grant);
    $display("test reset done");

    for (k = 0; k < 40; k++) begin
      r = $urandom;
      {i_locked_req, i_odd_second_req, i_coproc_next_req, i_exec_data_req, i_prefetch_req} = r[4:0];
      i_exec_data_pending = r[5];
      i_exec_data_lead = r[8:6];
      cyc(1);
      check("grant", exp_grant({r[4:2], 2'b00, r[1:0]}, r[5], r[8:6]), o_grant);
    end
    {i_locked_req, i_odd_second_req, i_coproc_next_req, i_exec_data_req, i_prefetch_req} = '0;
    i_exec_data_pending = 1'b0;
    $display("test priority done");

    i_exec_data_req = 1'b1;
    i_foreign_master_request = 1'b1;
    n = 0;
    while (o_foreign_master_grant !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    cyc(1);
    check("hold grant", 8'h01, o_foreign_master_grant);
    check("grant in hold", 8'h00, o_grant);
    // low half stands for phase 2; the grant keeps the bus off while stopped
    clk_run = 1'b0;
    #41;
    check("hold frozen", 8'h01, o_foreign_master_grant);
    clk_run = 1'b1;
    cyc(1);
    i_foreign_master_request = 1'b0;
    n = 0;
    while (o_grant === 7'h00 && n < 10) begin
      cyc(1);
      n++;
    end
    check("hold released", 8'h00, o_foreign_master_grant);
    check("own cycle back", 8'h02, o_grant);
    i_exec_data_req = 1'b0;
    $display("test hold done");

    wait_clocks = 4'($urandom_range(3, 1));
    vec = 8'($urandom);
    i_int_enable = 1'b1;
    i_int_request = 1'b1;
    n = 0;
    while (o_int_ack_cycle !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    i_int_request = 1'b0;
    check("ack cycle", 8'h01, o_int_ack_cycle);
    i_foreign_master_request = 1'b1;
    check("ack status", 8'h00, stat);
    check("ack lock", 8'h00, o_atomic_access_n);
    rises = 0;
    gap = 0;
    prev = 1'b1;
    n = 0;
    while (o_vector_valid !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
      if (o_int_ack_cycle === 1'b1 && !prev) rises++;
      if (o_int_ack_cycle === 1'b1 && !prev) check("ack2 status", 8'h00, stat);
      if (o_int_ack_cycle === 1'b0 && rises == 0) gap++;
      if (o_vector_valid !== 1'b1) check("ack2 lock", 8'h00, o_atomic_access_n);
      check("hold in ack", 8'h00, o_foreign_master_grant);
      prev = o_int_ack_cycle;
    end
    check("ack count", 8'h01, rises);
    check("ack gap", 8'h03, gap);
    check("vector", vec, o_vector);
    check("vector valid", 8'h01, o_vector_valid);
    n = 0;
    while (o_foreign_master_grant !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    check("hold after ack", 8'h01, o_foreign_master_grant);
    i_foreign_master_request = 1'b0;
    cyc(6);
    $display("test acknowledge done");

    for (m = 0; m < 2; m++) begin
      i_halt_instruction = (m == 0);
      i_multi_prot_fault = (m == 1);
      cyc(1);
      i_halt_instruction = 1'b0;
      i_multi_prot_fault = 1'b0;
      check("halt status", 8'h01, stat);
      check("halt addr bit", (m == 0) ? 8'h01 : 8'h00, o_addr_bit_1);
      check("halt mode", (m == 1) ? 8'h03 : 8'h02, {o_halted, o_shutdown});
      cyc(1);
      check("halt op end", 8'h0F, stat);
      i_exec_data_req = 1'b1;
      i_coproc_operand_req = 1'b1;
      seen = 1'b0;
      bad = 1'b0;
      repeat (6) begin
        cyc(1);
        seen |= o_grant[2];
        bad |= o_grant[1];
      end
      check("opnd in halt", 8'h01, seen);
      check("exec in halt", 8'h00, bad);
      if (m == 1) i_int_request = 1'b1;
      i_coproc_seg_overrun = 1'b1;
      cyc(1);
      i_coproc_seg_overrun = 1'b0;
      if (m == 1) begin
        cyc(4);
        bad = 1'b0;
        repeat (6) begin
          cyc(1);
          bad |= o_grant[2];
        end
        check("opnd blocked", 8'h00, bad);
        check("still down", 8'h03, {o_halted, o_shutdown});
        i_int_request = 1'b0;
        cyc(3);
        snap = {stat, o_halted, o_shutdown, o_addr_bit_1, o_atomic_access_n};
        clk_run = 1'b0;
        // restart off a tick, so the first edge after it is cleanly rising
        #41;
        check("frozen", snap, {stat, o_halted, o_shutdown, o_addr_bit_1, o_atomic_access_n});
        clk_run = 1'b1;
        cyc(1);
        i_nonmaskable_int = 1'b1;
      end
      n = 0;
      while (o_halted !== 1'b0 && n < 8) begin
        cyc(1);
        n++;
      end
      i_nonmaskable_int = 1'b0;
      check("halt exit", 8'h00, o_halted);
      i_exec_data_req = 1'b0;
      i_coproc_operand_req = 1'b0;
      cyc(6);
    end
    $display("test halt done");
    give_verdict();
  end
endmodule
